// *** core/fte_regs.svh ***
// Register offsets, field positions, flag positions and reset values
`ifndef FTE_REGS_SVH
`define FTE_REGS_SVH

// Byte offsets of the slave registers
`define FTE_OFF_CMD      8'h00
`define FTE_OFF_ADDR     8'h04
`define FTE_OFF_STATUS   8'h08
`define FTE_OFF_REGSEL   8'h0C
`define FTE_OFF_REGDATA  8'h10

// Command word fields
`define FTE_CMD_OP_MSB   3
`define FTE_CMD_OP_LSB   0
`define FTE_CMD_RD_MSB   8
`define FTE_CMD_RD_LSB   4
`define FTE_CMD_BIT_MSB  11
`define FTE_CMD_BIT_LSB  9
`define FTE_CMD_PTR_MSB  13
`define FTE_CMD_PTR_LSB  12
`define FTE_CMD_MODE_MSB 15
`define FTE_CMD_MODE_LSB 14
`define FTE_CMD_Q_MSB    21
`define FTE_CMD_Q_LSB    16

// Status word fields
`define FTE_STAT_BUSY    8

// Status register flag positions
`define FTE_FLAG_C       0
`define FTE_FLAG_Z       1
`define FTE_FLAG_N       2
`define FTE_FLAG_V       3
`define FTE_FLAG_S       4
`define FTE_FLAG_H       5
`define FTE_FLAG_T       6

// Pointer register pairs, low byte index
`define FTE_PTR_X_LO     5'h1A
`define FTE_PTR_Y_LO     5'h1C
`define FTE_PTR_Z_LO     5'h1E

// Reset values and steps
`define FTE_STATUS_REGISTER_RESET   8'h00
`define FTE_REG_RESET    8'h00
`define FTE_PTR_STEP     16'h0001

`endif

// *** core/fte_pkg.sv ***
// Types shared by the flag and transfer execution block
package fte_pkg;

    typedef enum logic [3:0] {
        NO_OP                    = 4'h0,
        ARITH_SHIFT_RIGHT_OP     = 4'h1,
        BIT_TO_TRANSFER_FLAG_OP  = 4'h2,
        TRANSFER_FLAG_TO_BIT_OP  = 4'h3,
        SIGN_FLAG_SET_OP         = 4'h4,
        SIGN_FLAG_CLEAR_OP       = 4'h5,
        OVERFLOW_SET_OP          = 4'h6,
        OVERFLOW_CLEAR_OP        = 4'h7,
        HALF_CARRY_SET_OP        = 4'h8,
        HALF_CARRY_CLEAR_OP      = 4'h9,
        INDIRECT_LOAD_OP         = 4'hA,
        DISPLACEMENT_LOAD_OP     = 4'hB,
        DIRECT_LOAD_OP           = 4'hC,
        INDIRECT_STORE_OP        = 4'hD,
        DISPLACEMENT_STORE_OP    = 4'hE
    } fte_op_t;

    typedef enum logic [1:0] {
        MODE_PLAIN    = 2'h0,
        MODE_POST_INC = 2'h1,
        MODE_PRE_DEC  = 2'h2
    } fte_mode_t;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_EX1  = 3'b010,
        PH_EX2  = 3'b100
    } fte_state_t;

endpackage : fte_pkg

// *** core/fte_alu_if.sv ***
// Operand and result bundle between the core and its flag unit
interface fte_alu_if;
    import fte_pkg::*;
    fte_op_t    op;
    logic [7:0] operand;
    logic [2:0] bit_sel;
    logic [7:0] status_register_in;
    logic [7:0] result;
    logic [7:0] status_register_out;

    modport alu  (input op, operand, bit_sel, status_register_in,
                  output result, status_register_out);
    modport core (output op, operand, bit_sel, status_register_in,
                  input result, status_register_out);
endinterface : fte_alu_if

// *** core/fte_alu.sv ***
// Single-cycle shift and flag unit
`include "fte_regs.svh"
module fte_alu
    import fte_pkg::*;
(
    // Operands in, results out
    fte_alu_if.alu p
);

    // Result and status for the single-cycle operations
    always_comb begin
        p.result   = p.operand;
        p.status_register_out = p.status_register_in;
        unique case (p.op)
            ARITH_SHIFT_RIGHT_OP: begin
                p.result = {p.operand[7], p.operand[7:1]};
                p.status_register_out[`FTE_FLAG_C] = p.operand[0];
                p.status_register_out[`FTE_FLAG_N] = p.operand[7];
                p.status_register_out[`FTE_FLAG_V] = p.operand[7] ^ p.operand[0];
                p.status_register_out[`FTE_FLAG_Z] = ~|{p.operand[7], p.operand[7:1]};
            end
            BIT_TO_TRANSFER_FLAG_OP: begin
                p.status_register_out[`FTE_FLAG_T] = p.operand[p.bit_sel];
            end
            TRANSFER_FLAG_TO_BIT_OP: begin
                p.result[p.bit_sel] = p.status_register_in[`FTE_FLAG_T];
            end
            SIGN_FLAG_SET_OP:    p.status_register_out[`FTE_FLAG_S] = 1'b1;
            SIGN_FLAG_CLEAR_OP:  p.status_register_out[`FTE_FLAG_S] = 1'b0;
            OVERFLOW_SET_OP:     p.status_register_out[`FTE_FLAG_V] = 1'b1;
            OVERFLOW_CLEAR_OP:   p.status_register_out[`FTE_FLAG_V] = 1'b0;
            HALF_CARRY_SET_OP:   p.status_register_out[`FTE_FLAG_H] = 1'b1;
            HALF_CARRY_CLEAR_OP: p.status_register_out[`FTE_FLAG_H] = 1'b0;
            default: begin
            end
        endcase
    end

endmodule : fte_alu

// *** core/fte_core.sv ***
// Flag and data transfer execution core with AHB-Lite control
// Behaviour
// - Shift right, keep bit 7, update Z,C,N,V
// - Copy selected register bit into T flag
// - Write T flag into selected register bit
// - Set or clear sign flag alone
// - Set or clear overflow flag alone
// - Set or clear half carry flag alone
// - Load at pointer, then increment pointer, two clocks
// - Decrement pointer, then load at it, two clocks
// - Load pointer plus displacement, Y/Z, pointer kept
// - Load from constant address, two clocks
// - Store at pointer, then increment pointer
// - Decrement pointer, then store at it
// - Store pointer plus displacement, pointer kept
//
// The register offsets and the AHB-Lite interface to the registers were left to the implementer.
`include "fte_regs.svh"
module fte_core
    import fte_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Data memory port
    output logic [15:0]      dm_addr,
    output logic [7:0]       dm_wdata,
    output logic             dm_we,
    output logic             dm_re,
    input  wire logic [7:0]  dm_rdata
);

    fte_alu_if alu_bus ();
    fte_alu u_alu (
        .p (alu_bus)
    );

    // Bus state
    logic        wr_pend, next_wr_pend;
    logic [7:0]  wr_addr, next_wr_addr;
    logic [31:0] next_hrdata;

    // Core state
    fte_state_t  state, next_state;
    fte_op_t     cmd_op, next_cmd_op;
    fte_mode_t   cmd_mode, next_cmd_mode;
    logic [4:0]  cmd_rd, next_cmd_rd;
    logic [2:0]  cmd_bit, next_cmd_bit;
    logic [4:0]  cmd_ptr_lo, next_cmd_ptr_lo;
    logic [5:0]  cmd_q, next_cmd_q;
    logic [15:0] cmd_k, next_cmd_k;
    logic [4:0]  reg_sel, next_reg_sel;
    logic [7:0]  status_register, next_status_register;
    logic [7:0]  regs [32];
    logic [7:0]  next_regs [32];
    logic [15:0] next_dm_addr;
    logic [7:0]  next_dm_wdata;
    logic        next_dm_we, next_dm_re;

    // Decode helpers
    logic        addr_phase, cmd_write, wr_legal;
    logic [1:0]  wr_ptr_sel;
    fte_op_t     wr_op;
    logic        is_mem, is_load, is_disp;
    logic [7:0]  sel_val;
    logic [15:0] ptr_val, eff_addr;

    assign addr_phase = hsel & hready & htrans[1];
    assign cmd_write  = wr_pend & (wr_addr == `FTE_OFF_CMD);
    assign wr_ptr_sel = hwdata[`FTE_CMD_PTR_MSB:`FTE_CMD_PTR_LSB];
    assign wr_op      = fte_op_t'(hwdata[`FTE_CMD_OP_MSB:`FTE_CMD_OP_LSB]);
    assign sel_val    = regs[cmd_rd];
    assign ptr_val    = {regs[cmd_ptr_lo + 5'h01], regs[cmd_ptr_lo]};
    assign is_load    = cmd_op inside {INDIRECT_LOAD_OP, DISPLACEMENT_LOAD_OP,
                                       DIRECT_LOAD_OP};
    assign is_disp    = cmd_op inside {DISPLACEMENT_LOAD_OP,
                                       DISPLACEMENT_STORE_OP};
    assign is_mem     = is_load | (cmd_op inside {INDIRECT_STORE_OP,
                                                  DISPLACEMENT_STORE_OP});

    // Commands with no pointer, a bad pointer or a bad mode are refused
    always_comb begin
        wr_legal = 1'b1;
        if (wr_ptr_sel == 2'h3 &&
            wr_op inside {INDIRECT_LOAD_OP, DISPLACEMENT_LOAD_OP,
                          INDIRECT_STORE_OP, DISPLACEMENT_STORE_OP}) begin
            wr_legal = 1'b0;
        end
        if (wr_ptr_sel == 2'h0 && wr_op inside {DISPLACEMENT_LOAD_OP,
                                             DISPLACEMENT_STORE_OP}) begin
            wr_legal = 1'b0;
        end
        if (hwdata[`FTE_CMD_MODE_MSB:`FTE_CMD_MODE_LSB] == 2'h3) begin
            wr_legal = 1'b0;
        end
        if (wr_op == NO_OP || 4'(wr_op) == 4'hF) begin
            wr_legal = 1'b0;
        end
    end

    // Effective data memory address
    always_comb begin
        if (cmd_op == DIRECT_LOAD_OP) begin
            eff_addr = cmd_k;
        end else if (is_disp) begin
            eff_addr = ptr_val + {10'h000, cmd_q};
        end else if (cmd_mode == MODE_PRE_DEC) begin
            eff_addr = ptr_val - `FTE_PTR_STEP;
        end else begin
            eff_addr = ptr_val;
        end
    end

    // Flag unit operands
    assign alu_bus.op      = cmd_op;
    assign alu_bus.operand = sel_val;
    assign alu_bus.bit_sel = cmd_bit;
    assign alu_bus.status_register_in = status_register;

    // Bus next state and read mux
    always_comb begin
        next_wr_pend = addr_phase & hwrite;
        next_wr_addr = addr_phase ? haddr : wr_addr;
        next_hrdata  = hrdata;
        if (addr_phase && !hwrite) begin
            unique case (haddr)
                `FTE_OFF_CMD:     next_hrdata = {10'h000, cmd_q, cmd_mode,
                                    cmd_ptr_lo[2:1] - 2'h1, cmd_bit,
                                    cmd_rd, cmd_op};
                `FTE_OFF_ADDR:    next_hrdata = {16'h0000, cmd_k};
                `FTE_OFF_STATUS:  next_hrdata = {23'h000000,
                                    state != PH_IDLE, status_register};
                `FTE_OFF_REGSEL:  next_hrdata = {27'h0000000, reg_sel};
                `FTE_OFF_REGDATA: next_hrdata = {24'h000000, regs[reg_sel]};
                default:          next_hrdata = 32'h00000000;
            endcase
        end
    end

    // Bus registers; zero wait states, always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= 8'h00;
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend   <= next_wr_pend;
            wr_addr   <= next_wr_addr;
            hrdata    <= next_hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Core next state: command launch, execution, register access
    always_comb begin
        next_state           = state;
        next_cmd_op          = cmd_op;
        next_cmd_mode        = cmd_mode;
        next_cmd_rd          = cmd_rd;
        next_cmd_bit         = cmd_bit;
        next_cmd_ptr_lo      = cmd_ptr_lo;
        next_cmd_q           = cmd_q;
        next_cmd_k           = cmd_k;
        next_reg_sel         = reg_sel;
        next_status_register = status_register;
        next_regs            = regs;
        next_dm_addr         = dm_addr;
        next_dm_wdata        = dm_wdata;
        next_dm_we           = 1'b0;
        next_dm_re           = 1'b0;
        unique case (state)
            PH_IDLE: begin
                if (cmd_write && wr_legal) begin
                    next_state      = PH_EX1;
                    next_cmd_op     = wr_op;
                    next_cmd_mode   = fte_mode_t'(hwdata[`FTE_CMD_MODE_MSB:
                                                         `FTE_CMD_MODE_LSB]);
                    next_cmd_rd     = hwdata[`FTE_CMD_RD_MSB:`FTE_CMD_RD_LSB];
                    next_cmd_bit    = hwdata[`FTE_CMD_BIT_MSB:`FTE_CMD_BIT_LSB];
                    next_cmd_q      = hwdata[`FTE_CMD_Q_MSB:`FTE_CMD_Q_LSB];
                    unique case (wr_ptr_sel)
                        2'h0:    next_cmd_ptr_lo = `FTE_PTR_X_LO;
                        2'h1:    next_cmd_ptr_lo = `FTE_PTR_Y_LO;
                        default: next_cmd_ptr_lo = `FTE_PTR_Z_LO;
                    endcase
                end
                if (wr_pend) begin
                    unique case (wr_addr)
                        `FTE_OFF_ADDR:    next_cmd_k = hwdata[15:0];
                        `FTE_OFF_STATUS:  next_status_register = hwdata[7:0];
                        `FTE_OFF_REGSEL:  next_reg_sel = hwdata[4:0];
                        `FTE_OFF_REGDATA: next_regs[reg_sel] = hwdata[7:0];
                        default: ;
                    endcase
                end
            end
            PH_EX1: begin
                if (is_mem) begin
                    // Address out now, data taken or written next clock
                    next_state    = PH_EX2;
                    next_dm_addr  = eff_addr;
                    next_dm_wdata = sel_val;
                    next_dm_re    = is_load;
                    next_dm_we    = ~is_load;
                    if (!is_disp && cmd_op != DIRECT_LOAD_OP) begin
                        if (cmd_mode == MODE_POST_INC) begin
                            {next_regs[cmd_ptr_lo + 5'h01],
                             next_regs[cmd_ptr_lo]} =
                                ptr_val + `FTE_PTR_STEP;
                        end else if (cmd_mode == MODE_PRE_DEC) begin
                            {next_regs[cmd_ptr_lo + 5'h01],
                             next_regs[cmd_ptr_lo]} = eff_addr;
                        end
                    end
                end else begin
                    // Single-cycle shift and flag operations
                    next_state           = PH_IDLE;
                    next_regs[cmd_rd]    = alu_bus.result;
                    next_status_register = alu_bus.status_register_out;
                end
            end
            PH_EX2: begin
                next_state = PH_IDLE;
                if (is_load) begin
                    next_regs[cmd_rd] = dm_rdata;
                end
            end
        endcase
    end

    // Core registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state           <= PH_IDLE;
            cmd_op          <= NO_OP;
            cmd_mode        <= MODE_PLAIN;
            cmd_rd          <= 5'h00;
            cmd_bit         <= 3'h0;
            cmd_ptr_lo      <= `FTE_PTR_X_LO;
            cmd_q           <= 6'h00;
            cmd_k           <= 16'h0000;
            reg_sel         <= 5'h00;
            status_register <= `FTE_STATUS_REGISTER_RESET;
            dm_addr         <= 16'h0000;
            dm_wdata        <= 8'h00;
            dm_we           <= 1'b0;
            dm_re           <= 1'b0;
            regs            <= '{default: `FTE_REG_RESET};
        end else begin
            state           <= next_state;
            cmd_op          <= next_cmd_op;
            cmd_mode        <= next_cmd_mode;
            cmd_rd          <= next_cmd_rd;
            cmd_bit         <= next_cmd_bit;
            cmd_ptr_lo      <= next_cmd_ptr_lo;
            cmd_q           <= next_cmd_q;
            cmd_k           <= next_cmd_k;
            reg_sel         <= next_reg_sel;
            status_register <= next_status_register;
            dm_addr         <= next_dm_addr;
            dm_wdata        <= next_dm_wdata;
            dm_we           <= next_dm_we;
            dm_re           <= next_dm_re;
            regs            <= next_regs;
        end
    end

    // Checks on execution
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic ex1;
    assign ex1 = (state == PH_EX1);
    chk_shift_keeps_msb: assert property (
        ex1 && cmd_op == ARITH_SHIFT_RIGHT_OP |=> state == PH_IDLE &&
        regs[$past(cmd_rd)] == {$past(sel_val[7]), $past(sel_val[7:1])} &&
        status_register[`FTE_FLAG_C] == $past(sel_val[0]))
        else $error("shift right result or carry wrong");
    chk_bit_to_t: assert property (
        ex1 && cmd_op == BIT_TO_TRANSFER_FLAG_OP |=>
        status_register[`FTE_FLAG_T] == $past(sel_val[cmd_bit]) &&
        status_register[5:0] == $past(status_register[5:0]))
        else $error("bit to transfer flag copy wrong");
    chk_t_to_bit: assert property (
        ex1 && cmd_op == TRANSFER_FLAG_TO_BIT_OP |=>
        $stable(status_register) &&
        regs[cmd_rd][cmd_bit] == $past(status_register[`FTE_FLAG_T]))
        else $error("transfer flag to bit copy wrong");
    chk_sign_flag_only: assert property (
        ex1 && cmd_op inside {SIGN_FLAG_SET_OP, SIGN_FLAG_CLEAR_OP} |=>
        status_register == (($past(status_register) &
        ~(8'h01 << `FTE_FLAG_S)) | ({7'h00, $past(cmd_op == SIGN_FLAG_SET_OP)}
        << `FTE_FLAG_S)))
        else $error("sign flag operation wrong");
    chk_overflow_only: assert property (
        ex1 && cmd_op inside {OVERFLOW_SET_OP, OVERFLOW_CLEAR_OP} |=>
        status_register[`FTE_FLAG_V] == $past(cmd_op == OVERFLOW_SET_OP) &&
        status_register[2:0] == $past(status_register[2:0]) &&
        status_register[7:4] == $past(status_register[7:4]))
        else $error("overflow flag operation wrong");
    chk_half_carry_only: assert property (
        ex1 && cmd_op inside {HALF_CARRY_SET_OP, HALF_CARRY_CLEAR_OP} |=>
        status_register[`FTE_FLAG_H] == $past(cmd_op == HALF_CARRY_SET_OP) &&
        status_register[4:0] == $past(status_register[4:0]))
        else $error("half carry flag operation wrong");
    chk_post_inc_ptr: assert property (
        ex1 && is_mem && !is_disp && cmd_op != DIRECT_LOAD_OP &&
        cmd_mode == MODE_POST_INC |=> dm_addr == $past(ptr_val) &&
        ptr_val == $past(ptr_val) + `FTE_PTR_STEP)
        else $error("post increment address or pointer wrong");
    chk_pre_dec_ptr: assert property (
        ex1 && is_mem && !is_disp && cmd_op != DIRECT_LOAD_OP &&
        cmd_mode == MODE_PRE_DEC |=> dm_addr == $past(ptr_val) -
        `FTE_PTR_STEP && ptr_val == dm_addr)
        else $error("pre decrement address or pointer wrong");
    chk_disp_ptr_kept: assert property (
        ex1 && is_disp |=> $stable(ptr_val) &&
        dm_addr == $past(ptr_val) + {10'h000, cmd_q})
        else $error("displacement address wrong or pointer moved");
    chk_load_two_clk: assert property (
        ex1 && is_load |=> dm_re && state == PH_EX2 ##1 state == PH_IDLE &&
        regs[cmd_rd] == $past(dm_rdata) && $stable(status_register))
        else $error("load not done in two clocks");
    chk_store_two_clk: assert property (
        ex1 && is_mem && !is_load |=> dm_we && !dm_re &&
        dm_wdata == $past(sel_val) ##1 state == PH_IDLE && !dm_we)
        else $error("store strobe or data wrong");
endmodule : fte_core

// *** verification/fte_mem_model.sv ***
// Behavioural data memory answering the core's memory port
module fte_mem_model (
    // Clock
    input  wire logic        hclk,
    // Memory port from the core
    input  wire logic [15:0] dm_addr,
    input  wire logic [7:0]  dm_wdata,
    input  wire logic        dm_we,
    input  wire logic        dm_re,
    output logic [7:0]       dm_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:255];
    logic [7:0] last = 8'h5A;
    // Drive data only while read, else the inverse of the last byte
    always_comb dm_rdata = dm_re ? mem[dm_addr[7:0]] : ~last;
    // Write at the edge ending the strobe, remember the last read
    always @(posedge hclk) begin
        if (dm_we) mem[dm_addr[7:0]] <= dm_wdata;
        if (dm_re) last <= mem[dm_addr[7:0]];
    end
endmodule : fte_mem_model

// *** verification/flag_and_transfer_exec_bench.sv ***
// Self-checking bench for the flag and transfer execution core
`include "fte_regs.svh"
module flag_and_transfer_exec_bench
    import fte_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] hwdata = 32'h0;
    logic        hreadyout, hresp, dm_we, dm_re;
    logic [31:0] hrdata;
    logic [15:0] dm_addr;
    logic [7:0]  dm_wdata, dm_rdata;
    logic        rd_ph = 1'b0;
    logic        rd_chk = 1'b0;
    logic [31:0] exp_q [$];
    logic [24:0] acc_q [$];
    int          mismatches = 0;
    int          n_tests = 0;
    integer      seed = 52;

    fte_core dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
        .dm_rdata(dm_rdata));
    fte_mem_model mem_u (.hclk(hclk), .dm_addr(dm_addr),
        .dm_wdata(dm_wdata), .dm_we(dm_we), .dm_re(dm_re),
        .dm_rdata(dm_rdata));

    // Clock
    always #2 hclk = ~hclk;

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop

    // One single AHB-Lite word transfer
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic chk);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        rd_ph <= !w;
        rd_chk <= chk;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_ph <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 1'b0);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0, 1'b1);
    endtask : rd

    task automatic run(input logic [31:0] c);
        int i;
        wr(`FTE_OFF_CMD, c);
        for (i = 0; i < 20; i++) begin
            xfer(1'b0, `FTE_OFF_STATUS, 32'h0, 1'b0);
            #1;
            if (hrdata[`FTE_STAT_BUSY] === 1'b0) break;
        end
        check("busy", {31'h0, hrdata[`FTE_STAT_BUSY]}, 32'h0);
    endtask : run

    function automatic logic [31:0] cmd(input logic [3:0] op,
        input logic [4:0] r, input logic [2:0] b, input int p, m,
        input logic [5:0] q);
        return {10'h0, q, 2'(m), 2'(p), b, r, op};
    endfunction : cmd

    task automatic set_reg(input logic [4:0] i, input logic [7:0] v);
        wr(`FTE_OFF_REGSEL, {27'h0, i});
        wr(`FTE_OFF_REGDATA, {24'h0, v});
    endtask : set_reg

    task automatic get_reg(input logic [4:0] i, input logic [7:0] e);
        wr(`FTE_OFF_REGSEL, {27'h0, i});
        rd(`FTE_OFF_REGDATA, {24'h0, e});
    endtask : get_reg

    task automatic ptr(input int p, input logic [15:0] v, input logic set);
        logic [4:0] lo;
        lo = `FTE_PTR_X_LO + 5'(2 * p);
        if (set) set_reg(lo, v[7:0]);
        if (set) set_reg(lo + 5'h1, v[15:8]);
        if (!set) get_reg(lo, v[7:0]);
        if (!set) get_reg(lo + 5'h1, v[15:8]);
    endtask : ptr

    // Expected bus reads and memory accesses, oldest first
    always @(posedge hclk) begin
        if (rd_ph && hreadyout && rd_chk)
            check("hrdata", hrdata, exp_q.pop_front());
        if (rd_ph && hreadyout)
            check("hresp", {31'h0, hresp}, 32'h0);
        if (dm_we || dm_re)
            check("dm_access", {7'h0, dm_we, dm_addr,
                  dm_we ? dm_wdata : 8'h00}, {7'h0, acc_q.pop_front()});
    end

    // Watchdog
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        logic [7:0]  v, s, res, m;
        logic [15:0] pt, ea, nx;
        logic [4:0]  d;
        logic [2:0]  b;
        logic [5:0]  q;
        int          k, p, md;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        wr(8'h14, 32'hFFFF_FFFF);
        rd(8'h14, 32'h0);
        for (k = 0; k < 6; k++) begin
            v = (k == 0) ? 8'h01 : (k == 1) ? 8'h80 : 8'($random(seed));
            d = {1'b0, 4'($random(seed))} + 5'h2;
            s = 8'($random(seed));
            b = 3'($random(seed));
            set_reg(d, v);
            wr(`FTE_OFF_STATUS, {24'h0, s});
            run(cmd(4'h1, d, 3'h0, 0, 0, 6'h0));
            res = {v[7], v[7:1]};
            get_reg(d, res);
            m = s;
            m[`FTE_FLAG_C] = v[0];
            m[`FTE_FLAG_Z] = (res == 8'h00);
            m[`FTE_FLAG_N] = res[7];
            m[`FTE_FLAG_V] = res[7] ^ v[0];
            rd(`FTE_OFF_STATUS, {24'h0, m});
            set_reg(d, v);
            run(cmd(4'h2, d, b, 0, 0, 6'h0));
            m[`FTE_FLAG_T] = v[b];
            rd(`FTE_OFF_STATUS, {24'h0, m});
            run(cmd(4'h3, d, b + 3'h1, 0, 0, 6'h0));
            res = v;
            res[b + 3'h1] = v[b];
            get_reg(d, res);
            rd(`FTE_OFF_STATUS, {24'h0, m});
        end
        for (k = 4; k < 10; k++) begin
            s = 8'($random(seed));
            wr(`FTE_OFF_STATUS, {24'h0, s});
            run(cmd(4'(k), 5'h0, 3'h0, 0, 0, 6'h0));
            m = s;
            m[(k < 6) ? 4 : (k < 8) ? 3 : 5] = (k % 2 == 0);
            rd(`FTE_OFF_STATUS, {24'h0, m});
        end
        for (p = 0; p < 3; p++) for (md = 0; md < 3; md++) begin
            pt = (p == 2 && md == 2) ? 16'h0000 : 16'($random(seed));
            v = 8'($random(seed));
            d = {1'b0, 4'($random(seed))};
            s = 8'($random(seed));
            wr(`FTE_OFF_STATUS, {24'h0, s});
            ptr(p, pt, 1'b1);
            ea = (md == 2) ? pt - 16'h1 : pt;
            mem_u.mem[ea[7:0]] = v;
            acc_q.push_back({1'b0, ea, 8'h00});
            run(cmd(4'hA, d, 3'h0, p, md, 6'h0));
            get_reg(d, v);
            nx = (md == 1) ? pt + 16'h1 : ea;
            ptr(p, nx, 1'b0);
            ea = (md == 2) ? nx - 16'h1 : nx;
            acc_q.push_back({1'b1, ea, v});
            run(cmd(4'hD, d, 3'h0, p, md, 6'h0));
            ptr(p, (md == 1) ? nx + 16'h1 : ea, 1'b0);
            rd(`FTE_OFF_STATUS, {24'h0, s});
        end
        for (p = 0; p < 3; p++) begin
            pt = 16'($random(seed));
            q = 6'($random(seed));
            v = 8'($random(seed));
            d = {1'b0, 4'($random(seed))};
            ea = pt + {10'h0, q};
            ptr(p, pt, 1'b1);
            set_reg(d, ~v);
            mem_u.mem[ea[7:0]] = v;
            if (p > 0) acc_q.push_back({1'b0, ea, 8'h00});
            run(cmd(4'hB, d, 3'h0, p, 0, q));
            get_reg(d, (p > 0) ? v : ~v);
            if (p > 0) acc_q.push_back({1'b1, ea, v});
            run(cmd(4'hE, d, 3'h0, p, 0, q));
            ptr(p, pt, 1'b0);
        end
        ea = 16'($random(seed));
        v = 8'($random(seed));
        mem_u.mem[ea[7:0]] = v;
        wr(`FTE_OFF_ADDR, {16'h0, ea});
        acc_q.push_back({1'b0, ea, 8'h00});
        run(cmd(4'hC, 5'h3, 3'h0, 0, 0, 6'h0));
        get_reg(5'h3, v);
        rd(`FTE_OFF_ADDR, {16'h0, ea});
        rd(`FTE_OFF_REGSEL, {27'h0, 5'h3});
        // Bad op, bad mode and bad pointer leave the command untouched
        for (k = 0; k < 3; k++) begin
            wr(`FTE_OFF_CMD, cmd((k == 0) ? 4'hF : (k == 1) ? 4'h2 : 4'hA,
                5'h7, 3'h1, (k == 2) ? 3 : 0, (k == 1) ? 3 : 0, 6'h1));
            rd(`FTE_OFF_CMD, cmd(4'hC, 5'h3, 3'h0, 0, 0, 6'h0));
        end
        repeat (2) @(posedge hclk);
        check("queues", 32'(exp_q.size() + acc_q.size()), 32'h0);
        report_and_stop();
    end
endmodule : flag_and_transfer_exec_bench
